//--- pctl_trip.sv
// protection channel trip logic, top level
// What this block does
// - assert each partial trip output when its parameter crosses its setpoint
// - compute overtemperature dt setpoint per loop, compare each loop separately
// - compute overpower dt setpoint per loop, compare each loop separately
// - manual injection block accepted only below pressure permissive, cancelled above it
// - steamline negative rate isolation enabled below permissive with low-pressure SI blocked
// - below half power, low-low level trip and feedwater start wait a delay
// - impulse pressure below setpoint signals low turbine power to low-power permissive
// - low-power permissive disables its assigned reactor trips
// - impulse pressure below rod control limit blocks automatic rod withdrawal
// - low range alarm at -5 % span, cleared at -2.5 % span
// - high range alarm at 105 % span, cleared at 102.5 % span
// - out-of-service input suppresses and clears its range alarms
// - range check all inputs except steamline rate and reactor power; extra validation only on delta/average temp channels
// - failure alarm follows the masked diagnostic detections; trouble alarm follows any detection or range alarm
// - high-high generator level issues turbine trip and feedwater isolation
`timescale 1ns/100ps
`include "pctl_regs.svh"
module pctl_trip import pctl_pkg::*; #(
  parameter int DLY_CYC = `PCTL_DLY_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire pctl_val_t [3:0]   loop_flow,
  input  wire pctl_val_t [3:0]   dt_loop,
  input  wire pctl_val_t [3:0]   tavg_loop,
  input  wire pctl_val_t         pzr_press,
  input  wire pctl_val_t         pzr_level,
  input  wire pctl_val_t [3:0]   stm_press,
  input  wire pctl_val_t [3:0]   stm_rate,
  input  wire pctl_val_t [3:0]   sg_level,
  input  wire pctl_val_t         imp_press,
  input  wire pctl_val_t         cont_press,
  input  wire pctl_val_t         rx_power,
  input  wire pctl_val_t         sp_flow_lo,
  input  wire pctl_val_t         sp_pzr_lvl_hi,
  input  wire pctl_val_t         sp_pzr_lo,
  input  wire pctl_val_t         sp_pzr_hi,
  input  wire pctl_val_t         sp_pzr_lolo,
  input  wire pctl_val_t         sp_p11,
  input  wire pctl_val_t         sp_stm_lo,
  input  wire pctl_val_t         sp_stm_rate,
  input  wire pctl_val_t         sp_sg_hh,
  input  wire pctl_val_t         sp_sg_ll,
  input  wire pctl_val_t         sp_p13,
  input  wire pctl_val_t         sp_p10,
  input  wire pctl_val_t         sp_c5,
  input  wire pctl_val_t         sp_cont_hi,
  input  wire pctl_val_t         sp_cont_hihi,
  input  wire logic              si_block_req,
  input  wire logic              stm_lo_si_blocked,
  input  wire logic [23:0]       in_oos,
  input  wire logic [7:0]        diag_fault,
  output pctl_trip_t             trip_r,
  output logic                   si_block_r,
  output logic [23:0]            range_lo_r,
  output logic [23:0]            range_hi_r,
  output logic [3:0]             dt_avg_invalid_r,
  output logic                   fail_alarm_r,
  output logic                   trouble_alarm_r
);
  localparam int NUM_IN = 24;
  localparam int CW     = $clog2(DLY_CYC + 1);
  // input slots in the range checker
  localparam int IX_FLOW = 0;
  localparam int IX_DT   = 4;
  localparam int IX_TAVG = 8;
  localparam int IX_STM  = 12;
  localparam int IX_SG   = 16;
  localparam int IX_PZRP = 20;
  localparam int IX_PZRL = 21;
  localparam int IX_IMP  = 22;
  localparam int IX_CONT = 23;

  if (DLY_CYC < 1) begin : g_bad
    $error("pctl_trip needs DLY_CYC of at least one");
  end

  typedef struct packed {
    pctl_trip_t           trip;
    logic                 blk;
    logic [3:0][CW-1:0]   dly;
    logic [3:0]           inval;
    logic                 fail;
    logic                 trouble;
  } pctl_st_t;

  pctl_st_t st_r;
  pctl_st_t st_nxt;

  pctl_rng_if #(.N(NUM_IN)) rng ();

  pctl_range #(.N(NUM_IN)) u_range (
    .clk   (clk),
    .rst_b (rst_b),
    .rng   (rng)
  );

  // k * (x - ref) / 16, computed in 32 bits, result truncated to 16 bits so it can wrap
  function automatic pctl_val_t lin(input pctl_val_t x, input pctl_val_t ref_v,
                                    input pctl_val_t k);
    logic signed [31:0] d;
    logic signed [31:0] p;
    d = 32'(x) - 32'(ref_v);
    p = (d * 32'(k)) >>> 4;
    return pctl_val_t'(p[15:0]);
  endfunction

  always_comb begin
    rng.val = '0;
    for (int i = 0; i < 4; i++) begin
      rng.val[IX_FLOW + i] = loop_flow[i];
      rng.val[IX_DT + i]   = dt_loop[i];
      rng.val[IX_TAVG + i] = tavg_loop[i];
      rng.val[IX_STM + i]  = stm_press[i];
      rng.val[IX_SG + i]   = sg_level[i];
    end
    rng.val[IX_PZRP] = pzr_press;
    rng.val[IX_PZRL] = pzr_level;
    rng.val[IX_IMP]  = imp_press;
    rng.val[IX_CONT] = cont_press;
  end
  assign rng.oos = in_oos;

  always_comb begin
    logic               low_turb;
    logic               low_pwr;
    logic               below_p11;
    logic               half;
    logic signed [17:0] tsum;
    pctl_val_t          tmean;
    pctl_val_t          ot_sp;
    pctl_val_t          op_sp;
    logic               bad;
    logic               dev;
    logic               raw_ll;
    logic               ll_any;
    st_nxt    = st_r;
    tsum      = '0;
    ll_any    = 1'b0;
    tmean     = '0;
    ot_sp     = '0;
    op_sp     = '0;
    bad       = 1'b0;
    dev       = 1'b0;
    raw_ll    = 1'b0;
    low_turb  = imp_press < sp_p13;
    low_pwr   = low_turb & (rx_power < sp_p10);
    below_p11 = pzr_press < sp_p11;
    half      = rx_power < $signed(`PCTL_HALF_POWER);
    for (int i = 0; i < 4; i++) begin
      tsum = tsum + 18'(tavg_loop[i]);
    end
    tmean = pctl_val_t'(tsum >>> 2);
    // manual block: taken only below the permissive, dropped above it
    if (!below_p11) begin
      st_nxt.blk = 1'b0;
    end else if (si_block_req) begin
      st_nxt.blk = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      ot_sp = pctl_val_t'(`PCTL_OT_K1) - lin(tavg_loop[i], `PCTL_TAVG_REF, `PCTL_OT_K2)
              + lin(pzr_press, `PCTL_PZR_REF, `PCTL_OT_K3);
      op_sp = pctl_val_t'(`PCTL_OP_K4)
              - lin(tavg_loop[i], `PCTL_TAVG_REF, `PCTL_OP_K5);
      // only these channels get checks beyond range
      dev = (tavg_loop[i] - tmean > $signed(`PCTL_DEV_LIM)) ||
            (tmean - tavg_loop[i] > $signed(`PCTL_DEV_LIM));
      bad = rng.lo[IX_DT + i] | rng.hi[IX_DT + i] | rng.lo[IX_TAVG + i] |
            rng.hi[IX_TAVG + i] | dev;
      st_nxt.inval[i] = bad;
      // invalid loop data trips rather than hides a real excursion
      st_nxt.trip.ot_dt[i] = (dt_loop[i] > ot_sp) | bad;
      st_nxt.trip.op_dt[i] = (dt_loop[i] > op_sp) | bad;
      st_nxt.trip.flow_lo[i] = (loop_flow[i] < sp_flow_lo) & ~low_pwr;
      st_nxt.trip.stm_lo_si[i] = stm_press[i] < sp_stm_lo;
      st_nxt.trip.stm_rate_iso[i] = below_p11 & stm_lo_si_blocked &
                                    (stm_rate[i] < sp_stm_rate);
      st_nxt.trip.sg_hh_turb_fw_iso[i] = sg_level[i] >= sp_sg_hh;
      raw_ll = sg_level[i] < sp_sg_ll;
      if (!raw_ll) begin
        st_nxt.dly[i] = '0;
      end else if (st_r.dly[i] != CW'(DLY_CYC)) begin
        st_nxt.dly[i] = st_r.dly[i] + CW'(1);
      end
      st_nxt.trip.sg_ll_rx_trip[i] = raw_ll & (~half |
                                     (st_r.dly[i] == CW'(DLY_CYC)));
      ll_any = ll_any | st_nxt.trip.sg_ll_rx_trip[i];
    end
    st_nxt.trip.auxiliary_feedwater_start = ll_any;
    st_nxt.trip.pzr_lvl_hi = (pzr_level > sp_pzr_lvl_hi) & ~low_pwr;
    st_nxt.trip.pzr_lo = (pzr_press < sp_pzr_lo) & ~low_pwr;
    st_nxt.trip.pzr_hi = pzr_press > sp_pzr_hi;
    st_nxt.trip.pzr_lolo_si = (pzr_press < sp_pzr_lolo) & ~st_nxt.blk;
    st_nxt.trip.p13_low_turb = low_turb;
    st_nxt.trip.p7_low_power = low_pwr;
    st_nxt.trip.c5_rod_block = imp_press < sp_c5;
    st_nxt.trip.cont_hi_si = cont_press > sp_cont_hi;
    st_nxt.trip.cont_hihi_spray = cont_press > sp_cont_hihi;
    st_nxt.fail = |(diag_fault & `PCTL_FAIL_MASK);
    st_nxt.trouble = (|diag_fault) | (|rng.lo) | (|rng.hi);
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bypass and manual trip switches act downstream of these flops
  assign trip_r          = st_r.trip;
  assign si_block_r      = st_r.blk;
  assign range_lo_r      = rng.lo;
  assign range_hi_r      = rng.hi;
  assign dt_avg_invalid_r = st_r.inval;
  assign fail_alarm_r    = st_r.fail;
  assign trouble_alarm_r = st_r.trouble;
endmodule

//--- pctl_regs.svh
// constants for the protection channel trip logic
`ifndef PCTL_REGS_SVH
`define PCTL_REGS_SVH
// analog values are signed, units of 0.1 % span
`define PCTL_RNG_LO_SET 16'hFFCE
`define PCTL_RNG_LO_RST 16'hFFE7
`define PCTL_RNG_HI_SET 16'h041A
`define PCTL_RNG_HI_RST 16'h0401
`define PCTL_HALF_POWER 16'h01F4
`define PCTL_CLK_MHZ 200
`define PCTL_DLY_TIME_US 1000
`define PCTL_DLY_CYCLES (`PCTL_DLY_TIME_US * `PCTL_CLK_MHZ)
`define PCTL_OT_K1 16'h0190
`define PCTL_OT_K2 16'h0010
`define PCTL_OT_K3 16'h0008
`define PCTL_OP_K4 16'h01C2
`define PCTL_OP_K5 16'h0008
`define PCTL_TAVG_REF 16'h0258
`define PCTL_PZR_REF 16'h0320
`define PCTL_DEV_LIM 16'h0032
`define PCTL_FAIL_MASK 8'h0F
`endif

//--- pctl_pkg.sv
// types shared by the protection channel trip logic
package pctl_pkg;
  typedef logic signed [15:0] pctl_val_t;
  typedef struct packed {
    logic [3:0] flow_lo;
    logic [3:0] ot_dt;
    logic [3:0] op_dt;
    logic       pzr_lvl_hi;
    logic       pzr_lo;
    logic       pzr_hi;
    logic       pzr_lolo_si;
    logic [3:0] stm_lo_si;
    logic [3:0] stm_rate_iso;
    logic [3:0] sg_hh_turb_fw_iso;
    logic [3:0] sg_ll_rx_trip;
    logic       auxiliary_feedwater_start;
    logic       p13_low_turb;
    logic       p7_low_power;
    logic       c5_rod_block;
    logic       cont_hi_si;
    logic       cont_hihi_spray;
  } pctl_trip_t;
endpackage

//--- pctl_rng_if.sv
// carrier between trip logic and its range checker
`timescale 1ns/100ps
interface pctl_rng_if #(parameter int N = 24);
  import pctl_pkg::*;
  pctl_val_t [N-1:0] val;
  logic      [N-1:0] oos;
  logic      [N-1:0] lo;
  logic      [N-1:0] hi;
  modport chk (input val, input oos, output lo, output hi);
  modport usr (output val, output oos, input lo, input hi);
endinterface

//--- pctl_range.sv
// range violation checker with hysteresis on each of its N input slots
`timescale 1ns/100ps
`include "pctl_regs.svh"
module pctl_range import pctl_pkg::*; #(
  parameter int N = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  pctl_rng_if.chk  rng
);
  typedef struct packed {
    logic [N-1:0] lo;
    logic [N-1:0] hi;
  } pctl_rs_t;

  pctl_rs_t st_r;
  pctl_rs_t st_nxt;

  if (N < 1) begin : g_bad
    $error("pctl_range needs at least one input");
  end

  // set wins; otherwise hold until the release level is reached
  function automatic logic hyst(input logic cur, input logic set, input logic rel);
    return set | (cur & ~rel);
  endfunction

  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < N; i++) begin
      st_nxt.lo[i] = hyst(st_r.lo[i], rng.val[i] <= $signed(`PCTL_RNG_LO_SET),
                          rng.val[i] >= $signed(`PCTL_RNG_LO_RST));
      st_nxt.hi[i] = hyst(st_r.hi[i], rng.val[i] >= $signed(`PCTL_RNG_HI_SET),
                          rng.val[i] <= $signed(`PCTL_RNG_HI_RST));
      if (rng.oos[i]) begin
        st_nxt.lo[i] = 1'b0;
        st_nxt.hi[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rng.lo = st_r.lo;
  assign rng.hi = st_r.hi;
endmodule

//--- pctl_vote.sv
// downstream voting model fed by the trip outputs
`timescale 1ns/100ps
module pctl_vote import pctl_pkg::*; (
  input  wire logic       clk,
  input  wire pctl_trip_t trip_r,
  input  wire logic       byp_spray,
  input  wire logic       byp_p13,
  input  wire logic       man_spray,
  output logic            spray_act,
  output logic            p13_act
);
  // switches act beside the comparator, so a bypass never masks a manual trip
  always_ff @(posedge clk) begin
    spray_act <= (trip_r.cont_hihi_spray & ~byp_spray) | man_spray;
    p13_act   <= trip_r.p13_low_turb & ~byp_p13;
  end
endmodule

//--- pctl_trip_chk.sv
// assertions on the trip logic ports
`timescale 1ns/100ps
module pctl_trip_chk import pctl_pkg::*; (
  input wire logic            clk,
  input wire logic            rst_b,
  input wire pctl_val_t [3:0] loop_flow,
  input wire pctl_val_t [3:0] stm_rate,
  input wire pctl_val_t [3:0] sg_level,
  input wire pctl_val_t       pzr_press,
  input wire pctl_val_t       imp_press,
  input wire pctl_val_t       rx_power,
  input wire pctl_val_t       sp_pzr_lo,
  input wire pctl_val_t       sp_p11,
  input wire pctl_val_t       sp_p13,
  input wire pctl_val_t       sp_c5,
  input wire pctl_val_t       sp_stm_rate,
  input wire pctl_val_t       sp_sg_hh,
  input wire pctl_val_t       sp_sg_ll,
  input wire logic            si_block_req,
  input wire logic            stm_lo_si_blocked,
  input wire logic [23:0]     in_oos,
  input wire logic [7:0]      diag_fault,
  input wire pctl_trip_t      trip_r,
  input wire logic            si_block_r,
  input wire logic [23:0]     range_lo_r,
  input wire logic            fail_alarm_r
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence slow_low;
    sg_level[0] < sp_sg_ll && rx_power < 16'sh01F4;
  endsequence
  // a fresh run of low samples, counter starts from zero
  sequence low7;
    !(sg_level[0] < sp_sg_ll) ##1 slow_low [*7];
  endsequence
  sequence low10;
    low7 ##1 slow_low [*3];
  endsequence
  sequence lo_band;
    !in_oos[0] && loop_flow[0] > 16'shFFCE && loop_flow[0] < 16'shFFE7;
  endsequence
  AST_PZR_LO:
    assert property (pzr_press < sp_pzr_lo && imp_press >= sp_p13 && !trip_r.p7_low_power
      |=> trip_r.pzr_lo) else $error("low pressure trip missing");
  AST_BLK_SET:
    assert property (si_block_req && pzr_press < sp_p11 |=> si_block_r)
      else $error("manual block not taken");
  AST_BLK_CLR:
    assert property (pzr_press >= sp_p11 |=> !si_block_r) else $error("manual block kept");
  AST_RATE:
    assert property (stm_rate[3] < sp_stm_rate && pzr_press < sp_p11 && stm_lo_si_blocked
      |=> trip_r.stm_rate_iso[3]) else $error("rate isolation missing");
  AST_TTD_WAIT:
    assert property (low7 |=> !trip_r.sg_ll_rx_trip[0]) else $error("low level trip early");
  AST_TTD_END:
    assert property (low10 |=> trip_r.sg_ll_rx_trip[0]) else $error("low level trip late");
  AST_P13:
    assert property (1'b1 |=> trip_r.p13_low_turb == $past(imp_press < sp_p13))
      else $error("turbine permissive wrong");
  AST_C5:
    assert property (1'b1 |=> trip_r.c5_rod_block == $past(imp_press < sp_c5))
      else $error("rod block wrong");
  AST_RNG_LO:
    assert property (!in_oos[0] && loop_flow[0] <= 16'shFFCE |=> range_lo_r[0])
      else $error("low range alarm missing");
  AST_RNG_HOLD:
    assert property (lo_band |=> range_lo_r[0] == $past(range_lo_r[0]))
      else $error("range alarm moved in band");
  AST_OOS:
    assert property (in_oos[0] |=> !range_lo_r[0]) else $error("alarm on idle input");
  AST_SG_HH:
    assert property (sg_level[1] >= sp_sg_hh |=> trip_r.sg_hh_turb_fw_iso[1])
      else $error("high-high level trip missing");
  AST_FAIL:
    assert property (1'b1 |=> fail_alarm_r == $past(|(diag_fault & 8'h0F)))
      else $error("failure alarm wrong");
endmodule

//--- pctl_trip_bench.sv
// self-checking bench for the protection channel trip logic
`timescale 1ns/100ps
module pctl_trip_bench import pctl_pkg::*; ;
  logic clk, rst_b, si_block_req, stm_lo_si_blocked, si_block_r, fail_alarm_r, trouble_alarm_r;
  pctl_val_t [3:0] loop_flow, dt_loop, tavg_loop, stm_press, stm_rate, sg_level;
  pctl_val_t pzr_press, pzr_level, imp_press, cont_press, rx_power, sp_flow_lo, sp_pzr_lvl_hi;
  pctl_val_t sp_pzr_lo, sp_pzr_hi, sp_pzr_lolo, sp_p11, sp_stm_lo, sp_stm_rate, sp_sg_hh;
  pctl_val_t sp_sg_ll, sp_p13, sp_p10, sp_c5, sp_cont_hi, sp_cont_hihi;
  logic [23:0] in_oos, range_lo_r, range_hi_r;
  logic [7:0]  diag_fault;
  logic [3:0]  dt_avg_invalid_r;
  pctl_trip_t  trip_r;
  logic        byp_spray, byp_p13, man_spray, spray_act, p13_act;
  int          err_count, comparisons;
  pctl_val_t   lv [4] = '{16'hFFCF, 16'hFFCE, 16'hFFE6, 16'hFFE7};
  pctl_val_t   hv [4] = '{16'h0419, 16'h041A, 16'h0402, 16'h0401};
  logic        ex [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  pctl_trip #(.DLY_CYC(8)) u_pctl_trip (.clk, .rst_b, .loop_flow, .dt_loop, .tavg_loop,
    .pzr_press, .pzr_level, .stm_press, .stm_rate, .sg_level, .imp_press, .cont_press,
    .rx_power, .sp_flow_lo, .sp_pzr_lvl_hi, .sp_pzr_lo, .sp_pzr_hi, .sp_pzr_lolo, .sp_p11,
    .sp_stm_lo, .sp_stm_rate, .sp_sg_hh, .sp_sg_ll, .sp_p13, .sp_p10, .sp_c5, .sp_cont_hi,
    .sp_cont_hihi, .si_block_req, .stm_lo_si_blocked, .in_oos, .diag_fault, .trip_r,
    .si_block_r, .range_lo_r, .range_hi_r, .dt_avg_invalid_r, .fail_alarm_r, .trouble_alarm_r);
  pctl_vote u_pctl_vote (.clk, .trip_r, .byp_spray, .byp_p13, .man_spray, .spray_act,
    .p13_act);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // whole run is some 80 cycles
  initial begin
    #5000;
    err_count++;
    stop_test();
  end
  initial begin
    {rst_b, si_block_req, stm_lo_si_blocked, byp_spray, byp_p13, man_spray} = 6'h00;
    {in_oos, diag_fault} = 32'h0000_0000;
    {loop_flow, dt_loop, tavg_loop} = {{4{16'h0320}}, {4{16'h0000}}, {4{16'h0258}}};
    {stm_press, stm_rate, sg_level} = {{4{16'h02BC}}, {4{16'h0000}}, {4{16'h01F4}}};
    {pzr_press, pzr_level, imp_press, cont_press} = 64'h0320_01F4_0320_0064;
    {rx_power, sp_flow_lo, sp_pzr_lvl_hi, sp_pzr_lo} = 64'h0320_012C_0384_0258;
    {sp_pzr_hi, sp_pzr_lolo, sp_p11, sp_stm_lo} = 64'h03B6_0226_02BC_0190;
    {sp_stm_rate, sp_sg_hh, sp_sg_ll, sp_p13} = 64'hFF9C_0384_00C8_012C;
    {sp_p10, sp_c5, sp_cont_hi, sp_cont_hihi} = 64'h01F4_00FA_012C_0258;
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1;
    chk({trip_r, range_lo_r, si_block_r}, 64'h0);
    step(2);
    chk(trip_r, 64'h0);
    dt_loop[2] = 16'h0191;
    step(2);
    chk({trip_r.ot_dt, trip_r.op_dt}, 8'h40);
    dt_loop[2] = 16'h0190;
    step(2);
    chk(trip_r.ot_dt, 4'h0);
    {dt_loop, tavg_loop} = {{4{16'h0000}}, {4{16'h02BC}}};
    dt_loop[1] = 16'h015E;
    step(2);
    chk({trip_r.ot_dt, trip_r.op_dt}, 8'h20);
    dt_loop[1] = 16'h0191;
    step(2);
    chk(trip_r.op_dt, 4'h2);
    {dt_loop, tavg_loop} = {{4{16'h0000}}, {4{16'h0258}}};
    pzr_press = 16'h021C;
    step(2);
    chk({trip_r.pzr_lo, trip_r.pzr_lolo_si}, 2'h3);
    si_block_req = 1;
    step(1);
    si_block_req = 0;
    step(1);
    chk({si_block_r, trip_r.pzr_lolo_si}, 2'h2);
    pzr_press = 16'h0320;
    step(2);
    chk(si_block_r, 1'b0);
    si_block_req = 1;
    step(2);
    chk(si_block_r, 1'b0);
    {si_block_req, stm_lo_si_blocked, pzr_press, stm_rate[3]} = 34'h1_028A_FF6A;
    step(2);
    chk(trip_r.stm_rate_iso, 4'h8);
    stm_lo_si_blocked = 0;
    step(2);
    chk(trip_r.stm_rate_iso, 4'h0);
    {pzr_press, stm_rate[3], imp_press} = 48'h0320_0000_0118;
    step(2);
    chk({trip_r.p13_low_turb, trip_r.p7_low_power, trip_r.c5_rod_block}, 3'h4);
    {rx_power, loop_flow[0]} = 32'h0190_00C8;
    step(2);
    chk({trip_r.p7_low_power, trip_r.flow_lo}, 5'h10);
    imp_press = 16'h00C8;
    step(2);
    chk(trip_r.c5_rod_block, 1'b1);
    {imp_press, rx_power} = 32'h0320_0320;
    step(2);
    chk(trip_r.flow_lo, 4'h1);
    {loop_flow[0], sg_level[1], sg_level[0]} = 48'h0320_03B6_0064;
    step(2);
    chk(trip_r.sg_hh_turb_fw_iso, 4'h2);
    chk({trip_r.sg_ll_rx_trip, trip_r.auxiliary_feedwater_start}, 5'h03);
    {sg_level[0], rx_power} = 32'h01F4_0190;
    step(2);
    sg_level[0] = 16'h0064;
    step(7);
    chk(trip_r.sg_ll_rx_trip, 4'h0);
    step(3);
    chk(trip_r.sg_ll_rx_trip, 4'h1);
    {sg_level, rx_power} = {{4{16'h01F4}}, 16'h0320};
    for (int i = 0; i < 4; i++) begin
      {loop_flow[0], pzr_level} = {lv[i], hv[i]};
      step(2);
      chk({range_lo_r[0], range_hi_r[21]}, {ex[i], ex[i]});
    end
    pzr_level = 16'h041A;
    step(2);
    chk({range_hi_r[21], trouble_alarm_r}, 2'h3);
    in_oos = 24'h200001;
    step(2);
    chk(range_hi_r[21], 1'b0);
    {in_oos, pzr_level, loop_flow[0], diag_fault} = {24'h0, 32'h01F4_0320, 8'h10};
    step(2);
    chk({fail_alarm_r, trouble_alarm_r}, 2'h1);
    diag_fault = 8'h01;
    step(2);
    chk(fail_alarm_r, 1'b1);
    {diag_fault, tavg_loop[0]} = 24'h00_02BC;
    step(3);
    chk({dt_avg_invalid_r, trip_r.ot_dt}, 8'h11);
    {cont_press, byp_spray, man_spray} = 18'h2BC_3;
    step(3);
    chk({trip_r.cont_hihi_spray, spray_act}, 2'h3);
    stop_test();
  end
endmodule
bind pctl_trip pctl_trip_chk u_pctl_trip_chk (.clk, .rst_b, .loop_flow, .stm_rate, .sg_level,
  .pzr_press, .imp_press, .rx_power, .sp_pzr_lo, .sp_p11, .sp_p13, .sp_c5, .sp_stm_rate,
  .sp_sg_hh, .sp_sg_ll, .si_block_req, .stm_lo_si_blocked, .in_oos, .diag_fault, .trip_r,
  .si_block_r, .range_lo_r, .fail_alarm_r);
